//--- shared/amp_cfg_defines.svh
// Register offsets, field positions, reset values and codes of the amplifier config slice
`ifndef AMP_CFG_DEFINES_SVH
`define AMP_CFG_DEFINES_SVH
`define ADDR_OUTPUT_STAGE   8'h06
`define ADDR_RESERVED_SLOT  8'h07
`define ADDR_FAULT_CFG      8'h08
`define OSC_PB_BIT          7
`define OSC_RATE_HI         6
`define OSC_RATE_LO         4
`define OSC_GAIN_HI         3
`define OSC_GAIN_LO         2
`define OSC_CH_BIT          1
`define OSC_RSVD_BIT        0
`define OSC_RESET           8'h51
`define FLT_THR_HI          5
`define FLT_THR_LO          4
`define FLT_CLK_BIT         3
`define FLT_OC_BIT          2
`define FLT_DC_BIT          1
`define FLT_OT_BIT          0
`define FLT_THR_RESET       2'h0
`define GAIN_RESERVED       2'h3
`define RATE_WIDTH          5
`define MULT_RESET          5'h10
`define FAULT_COUNT         3
`endif

//--- shared/amp_cfg_pkg.sv
// Types shared by the amplifier config slice
package amp_cfg_pkg;
  typedef enum logic [1:0] {
    RUN_ACTIVE,
    RUN_SHUTDOWN,
    RUN_HALTED
  } run_state_e;
endpackage

//--- test/amp_config_fault_regs_tb.sv
// Self-checking testbench for the amplifier config slice
`timescale 1ns/1ps
`default_nettype none
module amp_config_fault_regs_tb;
  logic       clk, rst, ce, sd_n, ds, cerr, oc, dc, ot, rv, pb, ch, oe, hwr, hrd;
  logic [7:0] addr, wdata, rdata, d;
  logic [4:0] mult;
  logic [1:0] gain, thr;
  int         error_cnt = 0;
  int         checked = 0;
  logic [4:0] rate_tbl [8] = '{5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18};
  amp_config_fault_regs dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr), .reg_wr(hwr), .reg_wdata(wdata),
    .reg_rd(hrd), .reg_rdata(rdata), .reg_rvalid(rv), .speaker_shutdown_n(sd_n), .double_speed(ds),
    .clock_error(cerr), .overcurrent_event(oc), .dc_offset_event(dc), .overtemp_event(ot),
    .parallel_bridge_enable(pb), .mono_channel_select(ch), .switching_multiple(mult),
    .analog_gain_select(gain), .overcurrent_threshold_select(thr), .output_enable(oe));
  host_model host (.clk(clk), .reg_addr(addr), .reg_wr(hwr), .reg_wdata(wdata), .reg_rd(hrd),
    .reg_rdata(rdata), .reg_rvalid(rv));
  // Free-running clock
  always #2 clk = ~clk;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Inputs always move one ns after the edge
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Guard against a hung run
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {clk, rst, ce, sd_n, ds, cerr, oc, dc, ot} = 9'h0E0;
    step(6);
    rst = 1'b0;
    host.rd(8'h06, d);
    chk(d, 8'h51);
    chk(mult, 5'h10);
    host.rd(8'h08, d);
    chk(d, 8'h00);
    host.rd(8'h09, d);
    chk(d, 8'h00);
    chk(oe, 1'b1);
    $display("reset test done");
    for (int k = 0; k < 16; k++) begin
      ds = k[0];
      host.wr(8'h06, {1'b0, k[3:1], 4'h1});
      step(2);
      chk(mult, ds ? rate_tbl[k[3:1]] >> 1 : rate_tbl[k[3:1]]);
      chk({pb, ch}, 2'h0);
    end
    ds = 1'b0;
    // Gain code 3 must leave the previous gain in place
    for (int g = 0; g < 4; g++) begin
      host.wr(8'h06, {4'hD, g[1:0], 2'h3});
      step(2);
      chk({pb, ch, gain}, {2'h3, g == 3 ? 2'h2 : g[1:0]});
      host.rd(8'h06, d);
      chk(d, {4'hD, g == 3 ? 2'h2 : g[1:0], 2'h3});
    end
    for (int t = 0; t < 4; t++) begin
      host.wr(8'h08, {2'h3, t[1:0], 4'hF});
      step(2);
      chk(thr, t[1:0]);
      host.rd(8'h08, d);
      chk(d, {2'h0, t[1:0], 4'h0});
    end
    // Clock enable low: the write is lost and the outputs hold their last setting
    ce = 1'b0;
    host.wr(8'h06, 8'h01);
    step(2);
    chk({pb, ch, gain}, 4'hE);
    ce = 1'b1;
    host.rd(8'h06, d);
    chk(d, 8'hDB);
    $display("config test done");
    for (int k = 0; k < 3; k++) begin
      {oc, dc, ot} = 3'h4 >> k;
      step(1);
      {oc, dc, ot} = 3'h0;
      step(1);
      chk(oe, 1'b0);
      host.rd(8'h08, d);
      chk(d, 8'h30 | (8'h04 >> k));
      chk(oe, 1'b0);
      sd_n = 1'b0;
      step(2);
      host.rd(8'h08, d);
      chk(d, 8'h30);
      sd_n = 1'b1;
      step(3);
      chk(oe, 1'b1);
    end
    $display("fault test done");
    cerr = 1'b1;
    step(3);
    chk(oe, 1'b0);
    host.rd(8'h08, d);
    chk(d, 8'h38);
    cerr = 1'b0;
    step(3);
    chk(oe, 1'b1);
    host.rd(8'h08, d);
    chk(d, 8'h30);
    $display("clock error test done");
    // Reset in mid-run must bring every configured field back to its reset value
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    chk({pb, ch, gain, thr}, 6'h00);
    chk(mult, 5'h10);
    host.rd(8'h06, d);
    chk(d, 8'h51);
    host.rd(8'h08, d);
    chk(d, 8'h00);
    chk(oe, 1'b1);
    $display("mid-run reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire

//--- test/amp_regs_monitor.sv
// Assertion checker for the amplifier config slice
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg_defines.svh"
module amp_regs_monitor (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   ce,
  input wire logic [7:0]             reg_addr,
  input wire logic                   reg_wr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   reg_rvalid,
  input wire logic                   speaker_shutdown_n,
  input wire logic                   double_speed,
  input wire logic                   clock_error,
  input wire logic                   overcurrent_event,
  input wire logic                   dc_offset_event,
  input wire logic                   overtemp_event,
  input wire logic                   parallel_bridge_enable,
  input wire logic                   mono_channel_select,
  input wire logic [`RATE_WIDTH-1:0] switching_multiple,
  input wire logic [1:0]             analog_gain_select,
  input wire logic [1:0]             overcurrent_threshold_select,
  input wire logic                   output_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Accepted writes to the two mapped registers
  logic w6;
  logic w8;
  assign w6 = ce && reg_wr && reg_addr == 8'h06;
  assign w8 = ce && reg_wr && reg_addr == 8'h08;
  // Every property asks for ce in the cycles it relies on, since a low ce freezes the outputs
  AST_PB: assert property (w6 ##1 ce |-> ##1 parallel_bridge_enable == $past(reg_wdata[7], 2))
    else $error("bridge mode bit wrong");
  AST_RATE: assert property (
    (w6 && reg_wdata[6:4] == 3'h7 && !double_speed) ##1 (ce && !double_speed)[*2]
    |-> switching_multiple == 5'h18) else $error("switching multiple wrong");
  AST_HALF: assert property (
    (w6 && reg_wdata[6:4] == 3'h7 && double_speed) ##1 (ce && double_speed)[*2]
    |-> switching_multiple == 5'h0C) else $error("double speed multiple wrong");
  AST_GAIN: assert property (
    (w6 && reg_wdata[3:2] != 2'h3) ##1 ce |-> ##1 analog_gain_select == $past(reg_wdata[3:2], 2))
    else $error("gain field wrong");
  AST_NO11: assert property (analog_gain_select != 2'h3) else $error("gain code 3 applied");
  AST_CH: assert property (w6 ##1 ce |-> ##1 mono_channel_select == $past(reg_wdata[1], 2))
    else $error("mono channel bit wrong");
  AST_THR: assert property (
    w8 ##1 ce |-> ##1 overcurrent_threshold_select == $past(reg_wdata[5:4], 2))
    else $error("threshold field wrong");
  AST_CLKF: assert property (
    clock_error ##1 (clock_error && ce && reg_rd && reg_addr == 8'h08) |=> reg_rdata[3])
    else $error("clock fault bit low");
  AST_CLKOE: assert property ((ce && clock_error)[*3] |=> !output_enable)
    else $error("runs with clock error");
  AST_FLT: assert property (
    (ce && speaker_shutdown_n && (overcurrent_event || dc_offset_event || overtemp_event)) ##1 ce
    |-> ##1 !output_enable) else $error("fault did not halt");
  AST_SD: assert property ((ce && !speaker_shutdown_n)[*2] |=> !output_enable)
    else $error("runs in shutdown");
  AST_RESTART: assert property (
    (ce && !speaker_shutdown_n) ##1 (ce && speaker_shutdown_n && !clock_error)
    |=> output_enable) else $error("no restart after shutdown pulse");
endmodule
bind amp_config_fault_regs amp_regs_monitor mon (.*);
`default_nettype wire

//--- test/host_model.sv
// Control-port host model driving the register strobes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // Bus idle at time zero
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  end
  // Reserved bits kept at reset level; released data shows no stale value
  task wr(input logic [7:0] a, input logic [7:0] d);
    if (a != 8'h07) begin
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = (a == 8'h06) ? (d | 8'h01) : (a == 8'h08) ? (d & 8'h3F) : d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
    end
  endtask
  // Read answer taken one edge after the strobe
  task rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hXX;
    if (a != 8'h07) begin
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      if (reg_rvalid === 1'b1) d = reg_rdata;
    end
  endtask
endmodule
`default_nettype wire

//--- verilog/amp_config_fault_regs.sv
// Output-stage configuration and fault status registers of the class-D amplifier
// Notes on behaviour
// - Bit 7 selects bridge or parallel-bridge
// - Bits 6:4 pick switching multiple, reset 101
// - Double speed halves the switching multiple
// - Gain bits 3:2, reset 00, 11 forbidden
// - Bit 1 picks mono channel: 0 right
// - Bits 5:4 scale overcurrent trip level
// - Clock fault bit follows live clock error
// - Overcurrent flag latches, halts until shutdown toggle
// - DC offset flag latches, halts until toggle
// - Overtemp flag latches, halts until toggle
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg_defines.svh"
module amp_config_fault_regs
  import amp_cfg_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // Register port from the control-port decoder
  input  wire logic [7:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  output logic                        reg_rvalid,
  // Core status inputs
  input  wire logic                   speaker_shutdown_n,
  input  wire logic                   double_speed,
  input  wire logic                   clock_error,
  input  wire logic                   overcurrent_event,
  input  wire logic                   dc_offset_event,
  input  wire logic                   overtemp_event,
  // Configuration outputs to the output stage
  output logic                        parallel_bridge_enable,
  output logic                        mono_channel_select,
  output logic      [`RATE_WIDTH-1:0] switching_multiple,
  output logic      [1:0]             analog_gain_select,
  output logic      [1:0]             overcurrent_threshold_select,
  output logic                        output_enable
);
  typedef struct packed {
    logic [7:0]             osc;
    logic [1:0]             thr;
    logic [7:0]             rdata;
    logic                   rvalid;
    logic                   pb;
    logic                   ch;
    logic [`RATE_WIDTH-1:0] mult;
    logic [1:0]             gain;
    logic [1:0]             thr_out;
    logic                   oe;
    run_state_e             run;
  } regs_s;

  regs_s                  st_ff;
  regs_s                  nxt_st;
  logic                   oc_flag;
  logic                   dc_flag;
  logic                   ot_flag;
  logic                   any_latched;
  logic [`RATE_WIDTH-1:0] mult_dec;
  logic [7:0]             fault_word;
  logic [`FAULT_COUNT-1:0] fault_events;
  logic [`FAULT_COUNT-1:0] fault_flags;

  // Latching fault inputs in fault-word bit order: overcurrent, DC offset, overtemperature
  assign fault_events = {overcurrent_event, dc_offset_event, overtemp_event};

  // One latch per latching fault, all cleared by the same shutdown level
  for (genvar i = 0; i < `FAULT_COUNT; i++) begin : g_fault
    fault_latch u_latch (
      .clk          (clk),
      .rst          (rst),
      .ce           (ce),
      .event_in     (fault_events[i]),
      .shutdown_low (!speaker_shutdown_n),
      .flag         (fault_flags[i])
    );
  end

  assign oc_flag = fault_flags[`FLT_OC_BIT];
  assign dc_flag = fault_flags[`FLT_DC_BIT];
  assign ot_flag = fault_flags[`FLT_OT_BIT];

  // Rate lookup from the stored code
  rate_decode u_rate (
    .code         (st_ff.osc[`OSC_RATE_HI:`OSC_RATE_LO]),
    .double_speed (double_speed),
    .multiple     (mult_dec)
  );

  assign any_latched = oc_flag | dc_flag | ot_flag;

  // Fault word; reserved top bits read zero
  always_comb begin
    fault_word = 8'h00;
    fault_word[`FLT_THR_HI:`FLT_THR_LO] = st_ff.thr;
    fault_word[`FLT_CLK_BIT] = clock_error;
    fault_word[`FLT_OC_BIT]  = oc_flag;
    fault_word[`FLT_DC_BIT]  = dc_flag;
    fault_word[`FLT_OT_BIT]  = ot_flag;
  end

  // Next state: register writes, read data, output stage control
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    // Writes to the analog config; a forbidden gain code keeps the old gain
    if (reg_wr && reg_addr == `ADDR_OUTPUT_STAGE) begin
      nxt_st.osc = reg_wdata;
      if (reg_wdata[`OSC_GAIN_HI:`OSC_GAIN_LO] == `GAIN_RESERVED) begin
        nxt_st.osc[`OSC_GAIN_HI:`OSC_GAIN_LO] = st_ff.osc[`OSC_GAIN_HI:`OSC_GAIN_LO];
      end
    end
    // Only the threshold field of the fault register is writable
    if (reg_wr && reg_addr == `ADDR_FAULT_CFG) begin
      nxt_st.thr = reg_wdata[`FLT_THR_HI:`FLT_THR_LO];
    end
    // Reads answer one cycle later; unmapped and reserved addresses read zero
    if (reg_rd) begin
      nxt_st.rvalid = 1'b1;
      case (reg_addr)
        `ADDR_OUTPUT_STAGE: nxt_st.rdata = st_ff.osc;
        `ADDR_FAULT_CFG:    nxt_st.rdata = fault_word;
        default:            nxt_st.rdata = 8'h00;
      endcase
    end
    // Decoded configuration to the output stage
    nxt_st.pb      = st_ff.osc[`OSC_PB_BIT];
    nxt_st.ch      = st_ff.osc[`OSC_CH_BIT];
    nxt_st.gain    = st_ff.osc[`OSC_GAIN_HI:`OSC_GAIN_LO];
    nxt_st.mult    = mult_dec;
    nxt_st.thr_out = st_ff.thr;
    // Run state: latched faults halt until a shutdown pulse, clock errors heal alone
    case (st_ff.run)
      RUN_ACTIVE: begin
        if (!speaker_shutdown_n) begin
          nxt_st.run = RUN_SHUTDOWN;
        end else if (any_latched) begin
          nxt_st.run = RUN_HALTED;
        end
      end
      RUN_HALTED: begin
        if (!speaker_shutdown_n) begin
          nxt_st.run = RUN_SHUTDOWN;
        end
      end
      RUN_SHUTDOWN: begin
        if (speaker_shutdown_n) begin
          nxt_st.run = RUN_ACTIVE;
        end
      end
      default: nxt_st.run = RUN_SHUTDOWN;
    endcase
    nxt_st.oe = (nxt_st.run == RUN_ACTIVE) && !any_latched && !clock_error;
  end

  // State register; everything freezes while ce is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff        <= '0;
      st_ff.osc    <= `OSC_RESET;
      st_ff.thr    <= `FLT_THR_RESET;
      st_ff.mult   <= `MULT_RESET;
      st_ff.run    <= RUN_SHUTDOWN;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata                    = st_ff.rdata;
  assign reg_rvalid                   = st_ff.rvalid;
  assign parallel_bridge_enable       = st_ff.pb;
  assign mono_channel_select          = st_ff.ch;
  assign switching_multiple           = st_ff.mult;
  assign analog_gain_select           = st_ff.gain;
  assign overcurrent_threshold_select = st_ff.thr_out;
  assign output_enable                = st_ff.oe;
endmodule
`default_nettype wire

//--- verilog/fault_latch.sv
// One latching fault flag, cleared while the shutdown input is low
`timescale 1ns/1ps
`default_nettype none
module fault_latch (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic event_in,
  input  wire logic shutdown_low,
  output logic      flag
);
  typedef struct packed {
    logic flag;
  } latch_s;
  latch_s st_ff;
  latch_s nxt_st;

  // Clear while shutdown is held low; an event in that time is not kept
  always_comb begin
    nxt_st = st_ff;
    if (shutdown_low) begin
      nxt_st.flag = 1'b0;
    end else if (event_in) begin
      nxt_st.flag = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign flag = st_ff.flag;
endmodule
`default_nettype wire

//--- verilog/rate_decode.sv
// Decodes the switching rate code into a frame-clock multiple
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg_defines.svh"
module rate_decode
  import amp_cfg_pkg::*;
(
  input  wire logic [2:0]             code,
  input  wire logic                   double_speed,
  output logic      [`RATE_WIDTH-1:0] multiple
);
  logic [`RATE_WIDTH-1:0] single;

  // Single-speed table
  always_comb begin
    case (code)
      3'h0:    single = 5'h06;
      3'h1:    single = 5'h08;
      3'h2:    single = 5'h0A;
      3'h3:    single = 5'h0C;
      3'h4:    single = 5'h0E;
      3'h5:    single = 5'h10;
      3'h6:    single = 5'h14;
      default: single = 5'h18;
    endcase
  end

  // Double speed halves the rate; all table entries are even so nothing is lost
  assign multiple = double_speed ? {1'b0, single[`RATE_WIDTH-1:1]} : single;
endmodule
`default_nettype wire
